// ==== hw/sbba_consts.vh ====
`ifndef SBBA_CONSTS_VH
`define SBBA_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SBBA_OFF_DATA 8'hb0
`define SBBA_OFF_INDEX 8'hb1
`define SBBA_OFF_SLAVE 8'hb2
`define SBBA_OFF_CTRL 8'hb3

// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define SBBA_BIT_PROT 7
`define SBBA_BIT_BUSY 5
`define SBBA_BIT_DETECT 3
`define SBBA_BIT_TEST 2
`define SBBA_BIT_ERR 1
`define SBBA_BIT_DIR 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBBA_RST_BYTE 8'h00
`define SBBA_RST_BIT 1'b0

// ----------------------------------------
// Timing: clock period and quarter bit periods in ns, quarter bit periods in clock cycles
// ----------------------------------------
`define SBBA_CLK_NS 50
`define SBBA_QTR_NORM_NS 2500
`define SBBA_QTR_TEST_NS 250
`define SBBA_QTR_NORM_CYC (`SBBA_QTR_NORM_NS / `SBBA_CLK_NS)
`define SBBA_QTR_TEST_CYC (`SBBA_QTR_TEST_NS / `SBBA_CLK_NS)

`endif

// ==== hw/sbba_top.v ====
`timescale 1ns/1ps
`include "sbba_consts.vh"

module sbba_top (
    input wire clock_in,
    input wire arst_n_in,
    input wire [7:0] cfg_addr_in,
    input wire cfg_wr_in,
    input wire [7:0] cfg_wdata_in,
    output reg [7:0] cfg_rdata_out,
    input wire scl_in,
    output wire scl_out,
    output reg scl_oe_out,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_out
);

// ----------------------------------------
// States and segments
// ----------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_START = 2'b01;
localparam ST_BIT = 2'b10;
localparam ST_STOP = 2'b11;

localparam SEG_ADDR_W = 3'd0;
localparam SEG_INDEX = 3'd1;
localparam SEG_WDATA = 3'd2;
localparam SEG_ADDR_R = 3'd3;
localparam SEG_RDATA = 3'd4;
localparam SEG_DONE = 3'd7;

reg [7:0] data_r;
reg [7:0] index_r;
reg [7:0] slave_r;
reg prot_r;
reg detect_r;
reg test_r;
reg busy_r;
reg err_r;
reg nack_r;
reg [1:0] state_r;
reg [2:0] seg_r;
reg [1:0] phase_r;
reg [3:0] bitcnt_r;
reg [7:0] shift_r;
reg [5:0] qcnt_r;
reg [2:0] scl_sync_r;
reg [2:0] sda_sync_r;
reg scl_f_r;
reg sda_f_r;
reg scl_oe_nxt;
reg sda_oe_nxt;

wire tick = (qcnt_r == 6'd0);
wire [31:0] qtr_w = test_r ? (`SBBA_QTR_TEST_CYC - 1) : (`SBBA_QTR_NORM_CYC - 1);
wire ctrl_wr = cfg_wr_in && (cfg_addr_in == `SBBA_OFF_CTRL);
wire launch = cfg_wr_in && (cfg_addr_in == `SBBA_OFF_SLAVE) && !busy_r;
wire bit_end = tick && (phase_r == 2'd3);
wire ack_end = (state_r == ST_BIT) && bit_end && (bitcnt_r == 4'd8);
wire ack_miss = ack_end && (seg_r != SEG_RDATA) && nack_r;
// Clock stretching: hold high phase until the line is seen high
wire scl_hold = (phase_r == 2'd1) && !scl_f_r && (state_r != ST_IDLE);

assign scl_out = 1'b0;
assign sda_out = 1'b0;

// ----------------------------------------
// Segment sequencing
// ----------------------------------------
function [2:0] next_seg;
    input [2:0] seg;
    input rd;
    input prot;
    begin
        case (seg)
            SEG_ADDR_W: next_seg = prot ? SEG_WDATA : SEG_INDEX;
            SEG_INDEX: next_seg = rd ? SEG_ADDR_R : SEG_WDATA;
            SEG_ADDR_R: next_seg = SEG_RDATA;
            default: next_seg = SEG_DONE;
        endcase
    end
endfunction

function [7:0] seg_byte;
    input [2:0] seg;
    begin
        case (seg)
            SEG_ADDR_W: seg_byte = {slave_r[7:1], 1'b0};
            SEG_INDEX: seg_byte = index_r;
            SEG_WDATA: seg_byte = data_r;
            SEG_ADDR_R: seg_byte = {slave_r[7:1], 1'b1};
            default: seg_byte = 8'hff;
        endcase
    end
endfunction

wire [2:0] seg_n = next_seg(seg_r, slave_r[`SBBA_BIT_DIR], prot_r);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        scl_sync_r <= 3'h7;
        sda_sync_r <= 3'h7;
        scl_f_r <= 1'b1;
        sda_f_r <= 1'b1;
    end else begin
        scl_sync_r <= {scl_sync_r[1:0], scl_in};
        sda_sync_r <= {sda_sync_r[1:0], sda_in};
        if (scl_sync_r[1] == scl_sync_r[2]) begin
            scl_f_r <= scl_sync_r[2];
        end
        if (sda_sync_r[1] == sda_sync_r[2]) begin
            sda_f_r <= sda_sync_r[2];
        end
    end
end

// ----------------------------------------
// Register file
// ----------------------------------------
always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        data_r <= `SBBA_RST_BYTE;
        index_r <= `SBBA_RST_BYTE;
        slave_r <= `SBBA_RST_BYTE;
        prot_r <= `SBBA_RST_BIT;
        detect_r <= `SBBA_RST_BIT;
        test_r <= `SBBA_RST_BIT;
        err_r <= `SBBA_RST_BIT;
    end else begin
        if (cfg_wr_in && cfg_addr_in == `SBBA_OFF_DATA) begin
            data_r <= cfg_wdata_in;
        end else if (ack_end && seg_r == SEG_RDATA) begin
            data_r <= shift_r;
        end
        if (cfg_wr_in && cfg_addr_in == `SBBA_OFF_INDEX) begin
            index_r <= cfg_wdata_in;
        end
        if (launch) begin
            slave_r <= cfg_wdata_in;
        end
        if (ctrl_wr) begin
            prot_r <= cfg_wdata_in[`SBBA_BIT_PROT];
            detect_r <= cfg_wdata_in[`SBBA_BIT_DETECT];
            test_r <= cfg_wdata_in[`SBBA_BIT_TEST];
        end
        // Set wins over the write-one clear
        if (ack_miss) begin
            err_r <= 1'b1;
        end else if (ctrl_wr && cfg_wdata_in[`SBBA_BIT_ERR]) begin
            err_r <= 1'b0;
        end
    end
end

always @* begin
    case (cfg_addr_in)
        `SBBA_OFF_DATA: cfg_rdata_out = data_r;
        `SBBA_OFF_INDEX: cfg_rdata_out = index_r;
        `SBBA_OFF_SLAVE: cfg_rdata_out = slave_r;
        `SBBA_OFF_CTRL: cfg_rdata_out = {prot_r, 1'b0, busy_r, 1'b0, detect_r, test_r, err_r, 1'b0};
        default: cfg_rdata_out = 8'h00;
    endcase
end

// ----------------------------------------
// Quarter-bit timer
// ----------------------------------------
always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        qcnt_r <= 6'd0;
    end else if (state_r == ST_IDLE || tick) begin
        qcnt_r <= qtr_w[5:0];
    end else if (!scl_hold) begin
        qcnt_r <= qcnt_r - 6'd1;
    end
end

// ----------------------------------------
// Transfer engine
// ----------------------------------------
always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        state_r <= ST_IDLE;
        busy_r <= 1'b0;
        seg_r <= SEG_ADDR_W;
        phase_r <= 2'd0;
        bitcnt_r <= 4'd0;
        shift_r <= 8'h00;
        nack_r <= 1'b0;
    end else begin
        if (tick && state_r != ST_IDLE) begin
            phase_r <= phase_r + 2'd1;
        end
        if (tick && phase_r == 2'd2) begin
            nack_r <= sda_f_r;
        end
        case (state_r)
            ST_IDLE: begin
                phase_r <= 2'd0;
                if (launch) begin
                    busy_r <= 1'b1;
                    state_r <= ST_START;
                    seg_r <= (prot_r && cfg_wdata_in[`SBBA_BIT_DIR]) ? SEG_ADDR_R : SEG_ADDR_W;
                end
            end
            ST_START: begin
                if (bit_end) begin
                    state_r <= ST_BIT;
                    bitcnt_r <= 4'd0;
                    shift_r <= seg_byte(seg_r);
                end
            end
            ST_BIT: begin
                if (tick && phase_r == 2'd2 && seg_r == SEG_RDATA && bitcnt_r != 4'd8) begin
                    shift_r <= {shift_r[6:0], sda_f_r};
                end
                if (bit_end) begin
                    if (bitcnt_r != 4'd8) begin
                        bitcnt_r <= bitcnt_r + 4'd1;
                        if (seg_r != SEG_RDATA) begin
                            shift_r <= {shift_r[6:0], 1'b1};
                        end
                    end else if (ack_miss || seg_n == SEG_DONE) begin
                        state_r <= ST_STOP;
                    end else if (seg_n == SEG_ADDR_R) begin
                        seg_r <= seg_n;
                        state_r <= ST_START;
                    end else begin
                        seg_r <= seg_n;
                        bitcnt_r <= 4'd0;
                        shift_r <= seg_byte(seg_n);
                    end
                end
            end
            ST_STOP: begin
                if (bit_end) begin
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------
// Pin drive
// ----------------------------------------
always @* begin
    scl_oe_nxt = 1'b0;
    sda_oe_nxt = 1'b0;
    case (state_r)
        ST_START: begin
            scl_oe_nxt = (phase_r == 2'd0) || (phase_r == 2'd3);
            sda_oe_nxt = phase_r[1];
        end
        ST_BIT: begin
            scl_oe_nxt = (phase_r == 2'd0) || (phase_r == 2'd3);
            if (bitcnt_r == 4'd8) begin
                sda_oe_nxt = 1'b0;
            end else if (seg_r != SEG_RDATA) begin
                sda_oe_nxt = !shift_r[7];
            end
        end
        ST_STOP: begin
            scl_oe_nxt = (phase_r == 2'd0);
            sda_oe_nxt = !phase_r[1];
        end
        default: scl_oe_nxt = 1'b0;
    endcase
end

always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        scl_oe_out <= 1'b0;
        sda_oe_out <= 1'b0;
    end else begin
        scl_oe_out <= scl_oe_nxt;
        sda_oe_out <= sda_oe_nxt;
    end
end

endmodule

// ==== tb/sbba_checker.sv ====
`timescale 1ns/1ps
module sbba_checker (
    input wire clock_in,
    input wire arst_n_in,
    input wire [7:0] cfg_addr_in,
    input wire cfg_wr_in,
    input wire [7:0] cfg_wdata_in,
    input wire [7:0] cfg_rdata_out,
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe_out,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    a_launch_sets_busy:
        assert property (cfg_wr_in && cfg_addr_in == 8'hb2 |-> ##2 (cfg_addr_in != 8'hb3 || cfg_rdata_out[5]))
        else $error("busy missing");
    a_launch_starts:
        assert property (cfg_wr_in && cfg_addr_in == 8'hb2 && !scl_oe_out && !sda_oe_out
            |-> ##[1:250] (sda_oe_out && !scl_oe_out)) else $error("no start");
    a_reg_write_seen:
        assert property (cfg_wr_in && cfg_addr_in[7:1] == 7'h58 |=> cfg_addr_in != $past(cfg_addr_in)
            || cfg_rdata_out == $past(cfg_wdata_in)) else $error("write lost");
    a_idle_released:
        assert property (cfg_addr_in == 8'hb3 && !cfg_rdata_out[5] |-> !scl_oe_out && !sda_oe_out)
        else $error("line held while idle");
    a_stop_then_idle:
        assert property (cfg_addr_in == 8'hb3 && cfg_rdata_out[5] ##1 cfg_addr_in == 8'hb3 && !cfg_rdata_out[5]
            |-> scl_in && sda_in) else $error("busy cleared before stop");
    a_err_sticky:
        assert property (cfg_addr_in == 8'hb3 && cfg_rdata_out[1] && !cfg_wr_in
            |=> cfg_addr_in != 8'hb3 || cfg_rdata_out[1]) else $error("error bit dropped");
    a_unmapped_zero:
        assert property (cfg_addr_in < 8'hb0 || cfg_addr_in > 8'hb3 |-> cfg_rdata_out == 8'h00)
        else $error("unmapped not zero");
    a_reserved_zero:
        assert property (cfg_addr_in == 8'hb3 |-> !cfg_rdata_out[6] && !cfg_rdata_out[4])
        else $error("reserved bit set");
endmodule
bind sbba_top sbba_checker chk (.*);

// ==== tb/sbba_slave_model.sv ====
`timescale 1ns/1ps
module sbba_slave_model #(parameter [6:0] DEV = 7'h50) (
    input wire scl_in,
    input wire sda_in,
    input wire stretch_in,
    output reg scl_oe_out = 0,
    output reg sda_oe_out = 0
);
    reg [7:0] mem [0:255];
    reg [7:0] sh, idx, tx;
    reg [3:0] n = 0;
    reg [2:0] st = 3;
    always @(negedge sda_in) if (scl_in) begin
        st = 0;
        n = 0;
    end
    always @(posedge sda_in) if (scl_in) st = 3;
    always @(posedge scl_in) if (n < 8) begin
        sh = {sh[6:0], sda_in};
        n = n + 1;
    end
    always @(negedge scl_in) begin
        if (n == 8) begin
            n = 9;
            sda_oe_out = 1;
            if (st == 0 && sh[7:1] == DEV) begin
                st = sh[0] ? 4 : 1;
                tx = mem[idx];
            end else if (st == 1) begin
                idx = sh;
                st = 2;
            end else if (st == 2) begin
                mem[idx] = sh;
                st = 3;
            end else begin
                st = 3;
                sda_oe_out = 0;
            end
        end else if (n == 9) begin
            n = 0;
            sda_oe_out = (st == 4) & ~tx[7];
        end else if (st == 4)
            sda_oe_out = ~tx[7 - n];
    end
    // Slow partner holds the clock low
    always @(negedge scl_in) if (stretch_in) begin
        scl_oe_out = 1;
        #3000 scl_oe_out = 0;
    end
endmodule

// ==== tb/serial_bus_byte_access_bench.sv ====
`timescale 1ns/1ps
module serial_bus_byte_access_bench;
    reg clock_in = 0;
    reg arst_n_in = 0;
    reg [7:0] addr = 0;
    reg [7:0] wdata = 0;
    reg wr = 0;
    reg stretch = 0;
    wire [7:0] rdata;
    wire scl_oe, sda_oe, s_scl_oe, s_sda_oe;
    wire scl_o, sda_o;
    wire scl = (scl_oe ? scl_o : 1'b1) && !s_scl_oe;
    wire sda = (sda_oe ? sda_o : 1'b1) && !s_sda_oe;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer k;
    sbba_top uut (.clock_in(clock_in), .arst_n_in(arst_n_in), .cfg_addr_in(addr), .cfg_wr_in(wr),
        .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe));
    sbba_slave_model slv (.scl_in(scl), .sda_in(sda), .stretch_in(stretch),
        .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe));
    initial forever #25 clock_in = ~clock_in;
    task chk(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock_in);
            addr <= a;
            wdata <= d;
            wr <= 1;
            @(posedge clock_in);
            wr <= 0;
        end
    endtask
    task rreg(input [7:0] a, input [7:0] exp);
        begin
            @(posedge clock_in);
            addr <= a;
            @(negedge clock_in);
            chk(rdata, exp);
        end
    endtask
    task wait_idle;
        begin
            @(posedge clock_in);
            addr <= 8'hb3;
            @(negedge clock_in);
            for (k = 0; k < 8000 && rdata[5] !== 1'b0; k = k + 1)
                @(negedge clock_in);
            chk(rdata & 8'h20, 8'h00);
        end
    endtask
    task test_done;
        begin
            $display("errors %0d checks %0d", error_cnt, samples_checked);
            if (error_cnt == 0 && samples_checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge clock_in);
        arst_n_in <= 1;
        for (k = 0; k < 5; k = k + 1)
            rreg(8'hb0 + k, 8'h00);
        wreg(8'hb0, 8'h77);
        wreg(8'hb1, 8'h5a);
        wreg(8'hb2, 8'ha0);
        wait_idle;
        chk(slv.mem[8'h5a], 8'h77);
        rreg(8'hb3, 8'h00);
        wreg(8'hb3, 8'h04);
        rreg(8'hb3, 8'h04);
        wreg(8'hb0, 8'ha5);
        wreg(8'hb1, 8'h3c);
        wreg(8'hb2, 8'ha0);
        rreg(8'hb3, 8'h24);
        rreg(8'hb2, 8'ha0);
        wait_idle;
        chk(slv.mem[8'h3c], 8'ha5);
        wreg(8'hb0, 8'h00);
        stretch <= 1;
        wreg(8'hb1, 8'h3c);
        wreg(8'hb2, 8'ha1);
        wait_idle;
        rreg(8'hb0, 8'ha5);
        stretch <= 0;
        wreg(8'hb2, 8'ha2);
        wait_idle;
        rreg(8'hb3, 8'h06);
        rreg(8'hb3, 8'h06);
        wreg(8'hb3, 8'h06);
        rreg(8'hb3, 8'h04);
        wreg(8'hb3, 8'h8c);
        rreg(8'hb3, 8'h8c);
        wreg(8'hb0, 8'h5a);
        wreg(8'hb2, 8'ha0);
        wait_idle;
        chk(slv.idx, 8'h5a);
        wreg(8'hb2, 8'ha1);
        wait_idle;
        rreg(8'hb0, 8'h77);
        rreg(8'hb3, 8'h8c);
        test_done;
    end
    initial begin
        #2000000;
        error_cnt = error_cnt + 1;
        test_done;
    end
endmodule
